// File: lamp_seq_defs.svh
`ifndef LAMP_SEQ_DEFS_SVH
`define LAMP_SEQ_DEFS_SVH
// Notes on behaviour
// - Lamp drive stays off unless device supply, inverter low monitor and inverter high monitor are all good.
// - With supplies good a strike attempt starts and the gate duty ramps up until strike.
// - Strike is recognised by lamp current being sensed.
// - Reaching the lamp voltage limit during the ramp ends the attempt and enters the fault state.
// - No strike after 65,536 lamp cycles of attempt enters the fault state.
// - Lamp overvoltage during strike disables both gates at once and enters the fault state.
// - After strike the run phase adjusts duty to regulate lamp current.
// - In run the duty is held back so lamp voltage never exceeds the limit.
// - In run, lamp current low for 65,536 lamp cycles disables the gates and enters fault.
// - Lamp overcurrent enters the fault state at once.
// - In fault, all lamp drive is off.
// - Fault stays latched until a supply monitor goes bad.
// - Lamp frequency is boosted 33% during strike and returns to normal after strike.
// - Inverter overvoltage turns the lamps off and restarts the sequence.

// ==========================================================
// Timing counts, in lamp cycles
`define STRIKE_TIMEOUT_CYCLES 17'h10000
`define LAMP_OUT_CYCLES 17'h10000
// Duty cycle field
`define DUTY_WIDTH 8
`define DUTY_RESET 8'h00
`define DUTY_MAX 8'hFF
// Strike boost: 33 percent
`define BOOST_PERCENT 8'h21
`endif

// File: lamp_seq_pkg.sv
package lamp_seq_pkg;
    typedef enum logic [3:0] {
        ST_OFF = 4'h1,
        ST_STRIKE = 4'h2,
        ST_RUN = 4'h4,
        ST_FAULT = 4'h8
    } seq_state_t;

    // Comparator results, already synchronised
    typedef struct packed {
        logic vcc_ok;
        logic inv_under_ok;
        logic inv_over_bad;
        logic lamp_over_volt;
        logic lamp_current;
        logic lamp_current_high;
        logic lamp_over_current;
    } sense_t;

    typedef struct packed {
        logic enable;
        logic boost;
        logic [7:0] duty;
    } drive_t;
endpackage

// File: sync2.sv
`timescale 1ns/100ps
module sync2 #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Data
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta;

    initial begin
        if (WIDTH < 1) begin
            $error("sync2: WIDTH must be at least 1");
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            meta <= '0;
            q <= '0;
        end else begin
            meta <= d;
            q <= meta;
        end
    end
endmodule // sync2

// File: lamp_fault_sequencer.sv
`timescale 1ns/100ps
`include "lamp_seq_defs.svh"
module lamp_fault_sequencer #(
    parameter int CYCLE_WIDTH = 17,
    parameter logic [16:0] STRIKE_TIMEOUT = `STRIKE_TIMEOUT_CYCLES,
    parameter logic [16:0] LAMP_OUT_TIME = `LAMP_OUT_CYCLES
) (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Comparator pins, asynchronous
    input wire logic vcc_ok,
    input wire logic inverter_undervoltage_monitor,
    input wire logic inverter_overvoltage_monitor,
    input wire logic lamp_voltage_sense,
    input wire logic lamp_current_sense,
    input wire logic lamp_current_high,
    input wire logic lamp_over_current,
    // Lamp-frequency cycle tick from the oscillator, same clock
    input wire logic lamp_cycle_tick,
    // Gate drive
    output lamp_seq_pkg::drive_t drive,
    output lamp_seq_pkg::seq_state_t state_out
);
    import lamp_seq_pkg::*;

    initial begin
        if (CYCLE_WIDTH != 17) begin
            $error("lamp_fault_sequencer: CYCLE_WIDTH must be 17");
        end
        if (STRIKE_TIMEOUT == 17'h00000 || LAMP_OUT_TIME == 17'h00000) begin
            $error("lamp_fault_sequencer: counts must be nonzero");
        end
    end

    // ==========================================================
    // Input synchronisers
    sense_t raw;
    sense_t s;
    assign raw = '{vcc_ok: vcc_ok,
                   inv_under_ok: inverter_undervoltage_monitor,
                   inv_over_bad: inverter_overvoltage_monitor,
                   lamp_over_volt: lamp_voltage_sense,
                   lamp_current: lamp_current_sense,
                   lamp_current_high: lamp_current_high,
                   lamp_over_current: lamp_over_current};

    sync2 #(.WIDTH($bits(sense_t))) u_sync (
        .clk(clk),
        .resetn(resetn),
        .d(raw),
        .q(s)
    );

    // ==========================================================
    // Supply qualification
    logic supplies_ok;
    assign supplies_ok = s.vcc_ok && s.inv_under_ok && !s.inv_over_bad;

    // ==========================================================
    // Sequencer
    seq_state_t state;
    seq_state_t next_state;
    logic [16:0] strike_count;
    logic [16:0] out_count;
    logic strike_expired;
    logic lamp_out;

    assign strike_expired = lamp_cycle_tick &&
                            (strike_count == STRIKE_TIMEOUT - 17'h00001);
    assign lamp_out = lamp_cycle_tick && !s.lamp_current &&
                      (out_count == LAMP_OUT_TIME - 17'h00001);

    always_comb begin
        next_state = state;
        case (state)
            ST_OFF: begin
                if (supplies_ok) begin
                    next_state = ST_STRIKE;
                end
            end
            ST_STRIKE: begin
                if (s.lamp_over_volt || s.lamp_over_current) begin
                    next_state = ST_FAULT;
                end else if (s.lamp_current) begin
                    next_state = ST_RUN;
                end else if (strike_expired) begin
                    next_state = ST_FAULT;
                end
            end
            ST_RUN: begin
                if (s.lamp_over_current || lamp_out) begin
                    next_state = ST_FAULT;
                end
            end
            ST_FAULT: next_state = ST_FAULT;
            default: next_state = ST_OFF;
        endcase
        // Any bad supply aborts and restarts, also unlatching fault
        if (!supplies_ok) begin
            next_state = ST_OFF;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state <= ST_OFF;
        end else begin
            state <= next_state;
        end
    end

    // ==========================================================
    // Strike timeout counter, lamp cycles
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            strike_count <= 17'h00000;
        end else if (state != ST_STRIKE) begin
            strike_count <= 17'h00000;
        end else if (lamp_cycle_tick) begin
            strike_count <= strike_count + 17'h00001;
        end
    end

    // ==========================================================
    // Lamp-out counter; only consecutive low cycles count
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            out_count <= 17'h00000;
        end else if (state != ST_RUN || s.lamp_current) begin
            out_count <= 17'h00000;
        end else if (lamp_cycle_tick) begin
            out_count <= out_count + 17'h00001;
        end
    end

    // ==========================================================
    // Duty control; steps once per lamp cycle to keep the ramp slow
    logic [7:0] duty;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            duty <= `DUTY_RESET;
        end else if (next_state == ST_OFF || next_state == ST_FAULT) begin
            duty <= `DUTY_RESET;
        end else if (lamp_cycle_tick) begin
            if (s.lamp_over_volt) begin
                if (state == ST_RUN && duty != `DUTY_RESET) begin
                    duty <= duty - 8'h01;
                end
            end else if (state == ST_STRIKE) begin
                if (duty != `DUTY_MAX) begin
                    duty <= duty + 8'h01;
                end
            end else if (state == ST_RUN) begin
                if (s.lamp_current_high && duty != `DUTY_RESET) begin
                    duty <= duty - 8'h01;
                end else if (!s.lamp_current_high &&
                             duty != `DUTY_MAX) begin
                    duty <= duty + 8'h01;
                end
            end
        end
    end

    // ==========================================================
    // Outputs, registered
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            drive <= '0;
            state_out <= ST_OFF;
        end else begin
            drive.enable <= (next_state == ST_STRIKE ||
                             next_state == ST_RUN);
            drive.boost <= (next_state == ST_STRIKE);
            drive.duty <= duty;
            state_out <= next_state;
        end
    end
endmodule // lamp_fault_sequencer

// File: lamp_fault_sequencer_assertions.sv
`timescale 1ns/100ps
module lamp_checker #(
    parameter logic [16:0] STRIKE_TIMEOUT = 17'h10000
) (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Pins
    input wire logic vcc_ok,
    input wire logic inverter_undervoltage_monitor,
    input wire logic inverter_overvoltage_monitor,
    input wire logic lamp_over_current,
    input wire logic lamp_cycle_tick,
    // Outputs
    input lamp_seq_pkg::drive_t drive,
    input lamp_seq_pkg::seq_state_t state_out
);
    import lamp_seq_pkg::*;
    logic sup;
    logic [16:0] ticks;
    assign sup = vcc_ok && inverter_undervoltage_monitor
        && !inverter_overvoltage_monitor;
    // ==========
    // Ticks spent in the current strike attempt
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ticks <= 17'h00000;
        end else if (state_out != ST_STRIKE) begin
            ticks <= 17'h00000;
        end else if (lamp_cycle_tick) begin
            ticks <= ticks + 17'h00001;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    a_off_no_drive: assert property (
        state_out == ST_OFF |-> !drive.enable) else $error("drive in off");
    a_fault_no_drive: assert property (
        state_out == ST_FAULT |-> !drive.enable) else $error("fault drive");
    // Four samples cover the two-stage synchroniser
    a_bad_supply_off: assert property (
        (!sup)[*4] |-> state_out == ST_OFF) else $error("not off");
    a_strike_boost: assert property (
        state_out == ST_STRIKE |-> drive.boost && drive.enable)
        else $error("strike without boost");
    a_run_no_boost: assert property (
        state_out == ST_RUN |-> !drive.boost && drive.enable)
        else $error("run drive wrong");
    a_overcur_fault: assert property (
        (state_out != ST_OFF && lamp_over_current && sup)[*3]
        |=> state_out == ST_FAULT) else $error("overcurrent ignored");
    a_fault_latched: assert property (
        sup[*4] ##0 state_out == ST_FAULT |=> state_out == ST_FAULT)
        else $error("fault released");
    a_duty_ramp: assert property (
        state_out == ST_STRIKE && $past(state_out) == ST_STRIKE
        |-> drive.duty - $past(drive.duty) inside {8'h00, 8'h01})
        else $error("ramp step wrong");
    a_strike_limit: assert property (
        state_out == ST_STRIKE |-> ticks < STRIKE_TIMEOUT)
        else $error("strike too long");
endmodule // lamp_checker
bind lamp_fault_sequencer lamp_checker #(
    .STRIKE_TIMEOUT(STRIKE_TIMEOUT)) chk_u (.clk(clk), .resetn(resetn),
    .vcc_ok(vcc_ok), .lamp_over_current(lamp_over_current),
    .inverter_undervoltage_monitor(inverter_undervoltage_monitor),
    .inverter_overvoltage_monitor(inverter_overvoltage_monitor),
    .lamp_cycle_tick(lamp_cycle_tick), .drive(drive),
    .state_out(state_out));

// File: lamp_model.sv
`timescale 1ns/100ps
module lamp_model (
    // Clock
    input wire logic clk,
    // Drive and scenario controls
    input lamp_seq_pkg::drive_t drive,
    input wire logic dead,
    input wire logic over_v,
    // Sensing
    output logic cur,
    output logic cur_high,
    output logic volt_max,
    output logic tick
);
    import lamp_seq_pkg::*;
    logic [1:0] div = 2'h0;
    // Lamp fires past a few duty steps; a dead lamp never conducts
    assign cur = drive.enable && !dead && drive.duty > 8'h04;
    assign cur_high = cur && drive.duty > 8'h08;
    assign volt_max = over_v;
    always_ff @(posedge clk) div <= div + 2'h1;
    assign tick = div == 2'h3;
endmodule // lamp_model

// File: lamp_fault_sequencer_bench.sv
`timescale 1ns/100ps
module lamp_fault_sequencer_bench;
    import lamp_seq_pkg::*;
    localparam logic [16:0] LIM = 17'h00010;
    localparam logic [2:0] GOOD = 3'h6;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic [2:0] sup = 3'h0;
    logic ovc = 1'b0;
    logic dead = 1'b0;
    logic over_v = 1'b0;
    logic cur, cur_high, volt_max, tick;
    drive_t drive;
    seq_state_t state_out;
    int err_count = 0;
    int tests_run = 0;
    int n;
    initial forever #2 clk = ~clk;
    lamp_fault_sequencer #(.STRIKE_TIMEOUT(LIM), .LAMP_OUT_TIME(LIM)) dut_u (
        .clk(clk), .resetn(resetn), .vcc_ok(sup[2]),
        .inverter_undervoltage_monitor(sup[1]),
        .inverter_overvoltage_monitor(sup[0]),
        .lamp_voltage_sense(volt_max), .lamp_current_sense(cur),
        .lamp_current_high(cur_high), .lamp_over_current(ovc),
        .lamp_cycle_tick(tick), .drive(drive), .state_out(state_out));
    lamp_model lamp_u (.clk(clk), .drive(drive), .dead(dead),
        .over_v(over_v), .cur(cur), .cur_high(cur_high),
        .volt_max(volt_max), .tick(tick));
    task automatic check(input logic ok, input string what);
        tests_run++;
        if (ok !== 1'b1) begin
            err_count++;
            $display("ERROR %0t %s", $time, what);
        end
    endtask
    // Bounded wait, counting lamp ticks on the way
    task automatic wait_for(input seq_state_t s);
        n = 0;
        for (int i = 0; i < 400 && state_out !== s; i++) begin
            @(negedge clk);
            n += int'(tick === 1'b1);
        end
        // A wait that runs out is a failure in its own right
        if (state_out !== s) begin
            err_count++;
            $display("ERROR %0t state wait timed out", $time);
        end
    endtask
    task automatic give_verdict;
        $display("checks %0d errors %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic t_supplies;
        for (int v = 0; v < 8; v++) begin
            sup = 3'(v);
            repeat (8) @(negedge clk);
            if (v != 6) check(state_out === ST_OFF && !drive.enable, "on");
        end
        // Loop leaves the high monitor tripped
        sup = GOOD;
        wait_for(ST_STRIKE);
        check(drive.boost === 1'b1 && drive.enable === 1'b1, "strike");
        wait_for(ST_RUN);
        check(drive.boost === 1'b0, "boost left on");
        repeat (60) @(negedge clk);
        check(drive.duty inside {[8'h06:8'h0B]}, "no regulation");
        $display("supplies and strike done");
    endtask
    // Voltage limit in run pulls duty down but keeps the lamp running
    task automatic t_volt_limit;
        logic [7:0] d0;
        d0 = drive.duty;
        over_v = 1'b1;
        repeat (16) @(negedge clk);
        check(drive.duty < d0 && state_out === ST_RUN, "duty not cut");
        over_v = 1'b0;
        repeat (60) @(negedge clk);
        check(state_out === ST_RUN, "run lost after limit");
        $display("voltage limit done");
    endtask
    task automatic t_faults;
        for (int k = 0; k < 3; k++) begin
            ovc = 1'b1;
            wait_for(ST_FAULT);
            check(n <= 1 && drive.enable === 1'b0, "overcurrent");
            ovc = 1'b0;
            repeat (40) @(negedge clk);
            check(state_out === ST_FAULT, "fault cleared");
            sup = GOOD ^ (3'h4 >> k);
            wait_for(ST_OFF);
            check(state_out === ST_OFF, "fault stuck");
            sup = GOOD;
            wait_for(ST_RUN);
        end
        $display("fault latch done");
    endtask
    task automatic t_strike_fail(input logic ov);
        sup = 3'h0;
        dead = 1'b1;
        wait_for(ST_OFF);
        sup = GOOD;
        wait_for(ST_STRIKE);
        over_v = ov;
        wait_for(ST_FAULT);
        if (ov) check(n <= 1 && !drive.enable, "overvoltage");
        else check(n >= 15 && n <= 17, "strike timeout");
        {over_v, dead, sup} = 5'h00;
        wait_for(ST_OFF);
        sup = GOOD;
        wait_for(ST_RUN);
        $display("strike failure done");
    endtask
    task automatic t_lamp_out;
        dead = 1'b1;
        repeat (40) @(negedge clk);
        dead = 1'b0;
        repeat (8) @(negedge clk);
        check(state_out === ST_RUN, "early lamp out");
        dead = 1'b1;
        wait_for(ST_FAULT);
        check(n >= 15 && n <= 17 && !drive.enable, "lamp out");
        $display("lamp out done");
    endtask
    initial begin
        #100000;
        err_count++;
        give_verdict();
    end
    initial begin
        repeat (12) @(negedge clk);
        resetn = 1'b1;
        t_supplies();
        t_volt_limit();
        t_faults();
        t_strike_fail(1'b0);
        t_strike_fail(1'b1);
        t_lamp_out();
        give_verdict();
    end
endmodule // lamp_fault_sequencer_bench
